/* src/bcoc_chan.sv */
// One clock output: skew line, runt-free gate, polarity and enable
`timescale 1ns/1ps
module bcoc_chan
   import bcoc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Source clock level
   input  wire logic              src_i,
   // Static configuration
   input  wire logic [SKEW_W-1:0] skew_i,
   input  wire logic              coarse_i,
   input  wire logic              bypass_i,
   input  wire logic              inv_i,
   // Gate request (1 = run) and driver enable
   input  wire logic              run_i,
   input  wire logic              drive_i,
   // Pin side
   output logic                   q_o,
   output logic                   oe_o
);
   typedef struct packed {
      logic [LINE_LEN-1:0] line;
      logic                open;
      logic                q;
      logic                oe;
   } bcoc_chan_st_t;

   bcoc_chan_st_t st;
   bcoc_chan_st_t next_st;
   logic [TAP_W-1:0] tap_idx;
   logic             tap;

   always_comb begin
      if (bypass_i) begin
         tap_idx = '0;
      end else if (coarse_i) begin
         tap_idx = TAP_W'({1'b0, skew_i} * COARSE_UNIT_CYC);
      end else begin
         tap_idx = TAP_W'({1'b0, skew_i} * FINE_UNIT_CYC);
      end
      tap = st.line[tap_idx];
   end

   // Next state
   always_comb begin
      next_st = st;
      if (ce_i) begin
         next_st.line = {st.line[LINE_LEN-2:0], src_i};
         // gate moves only while the clock is low
         if (!tap) begin
            next_st.open = run_i;
         end
         // closed gate parks at polarity level
         next_st.q  = inv_i ^ (st.open & tap);
         next_st.oe = drive_i;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '{line: LINE_RST, open: 1'b0, q: 1'b0, oe: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign q_o  = st.q;
   assign oe_o = st.oe;

   // Checks
   property p_park;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !st.open) |=> (q_o == $past(inv_i));
   endproperty
   a_park: assert property (p_park)
      else $error("closed gate did not park at polarity level");

   property p_norunt;
      @(posedge clk_i) disable iff (rst_i)
      (st.open != $past(st.open)) |-> ($past(tap) == 1'b0);
   endproperty
   a_norunt: assert property (p_norunt)
      else $error("gate changed while clock high");

   property p_bypass;
      @(posedge clk_i) disable iff (rst_i)
      bypass_i |-> (tap_idx == 5'h00);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("skew applied in bypass");

   property p_coarse;
      @(posedge clk_i) disable iff (rst_i)
      (!bypass_i && coarse_i) |-> (tap_idx == {skew_i, 1'b0});
   endproperty
   a_coarse: assert property (p_coarse)
      else $error("coarse tap is not twice the setting");

   property p_fine;
      @(posedge clk_i) disable iff (rst_i)
      (!bypass_i && !coarse_i) |-> (tap_idx == {1'b0, skew_i});
   endproperty
   a_fine: assert property (p_fine)
      else $error("fine tap differs from setting");
endmodule : bcoc_chan

/* src/bcoc_pkg.sv */
// Constants and codes shared by the clock output bank control
package bcoc_pkg;
   // Geometry
   localparam int NUM_BANKS = 5;
   localparam int NUM_OUTS  = 2 * NUM_BANKS;
   localparam int SKEW_W    = 4;
   localparam int STD_W     = 4;
   localparam int SLEW_W    = 2;
   localparam int IMP_W     = 3;
   localparam int MODE_W    = 2;

   // Stored enable modes
   localparam logic [MODE_W-1:0] MODE_ALWAYS_OFF = 2'h0;
   localparam logic [MODE_W-1:0] MODE_ALWAYS_ON  = 2'h1;
   localparam logic [MODE_W-1:0] MODE_ON_X       = 2'h2;
   localparam logic [MODE_W-1:0] MODE_ON_Y       = 2'h3;

   // Logic standards; codes from STD_DIFF_FIRST up are differential
   localparam logic [STD_W-1:0] STD_LVTTL       = 4'h0;
   localparam logic [STD_W-1:0] STD_LVCMOS18    = 4'h1;
   localparam logic [STD_W-1:0] STD_LVCMOS25    = 4'h2;
   localparam logic [STD_W-1:0] STD_LVCMOS33    = 4'h3;
   localparam logic [STD_W-1:0] STD_SSTL        = 4'h4;
   localparam logic [STD_W-1:0] STD_HSTL        = 4'h5;
   localparam logic [STD_W-1:0] STD_LVDS        = 4'h6;
   localparam logic [STD_W-1:0] STD_LVPECL      = 4'h7;
   localparam logic [STD_W-1:0] STD_DIFF_FIRST  = 4'h6;

   // Slew used by the low-swing drivers
   localparam logic [SLEW_W-1:0] SLEW_FIXED = 2'h0;
   // Impedance codes: n gives 40 + 5n ohm for n in 0..6, 7 gives ~20 ohm
   localparam logic [IMP_W-1:0]  IMP_40_OHM = 3'h0;
   localparam logic [IMP_W-1:0]  IMP_LOW    = 3'h7;

   // Unit delay in clock cycles: fine is one reference clock cycle,
   // coarse twice that
   localparam int FINE_UNIT_CYC   = 1;
   localparam int COARSE_UNIT_CYC = 2 * FINE_UNIT_CYC;
   localparam int MAX_SKEW        = 15;
   localparam int LINE_LEN        = MAX_SKEW * COARSE_UNIT_CYC + 1;
   localparam int TAP_W           = 5;

   // Reset values
   localparam logic [LINE_LEN-1:0] LINE_RST = '0;
endpackage : bcoc_pkg

/* src/bcoc_top.sv */
// Clock output bank control: enables, gating, polarity, drive config
`timescale 1ns/1ps
module bcoc_top
   import bcoc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                        REF_CLK_I,
   input  wire logic                        SYS_RST_I,
   input  wire logic                        CE_I,
   // Internal clock source level
   input  wire logic                        SRC_CLK_I,
   // Control pins (asynchronous)
   input  wire logic                        ALL_OUTPUTS_ENABLE_N_I,
   input  wire logic                        SECONDARY_ENABLE_X_N_I,
   input  wire logic                        SECONDARY_ENABLE_Y_N_I,
   input  wire logic                        SYNC_OUTPUT_GATE_I,
   // Static configuration
   input  wire logic [NUM_OUTS*MODE_W-1:0]  OUT_MODE_I,
   input  wire logic [NUM_OUTS-1:0]         OUT_INVERT_I,
   input  wire logic [NUM_BANKS-1:0]        BANK_GATED_I,
   input  wire logic [NUM_BANKS*STD_W-1:0]  BANK_STD_I,
   input  wire logic [NUM_OUTS*SLEW_W-1:0]  OUT_SLEW_I,
   input  wire logic [NUM_OUTS*IMP_W-1:0]   OUT_IMP_I,
   input  wire logic [NUM_OUTS*SKEW_W-1:0]  OUT_SKEW_I,
   input  wire logic                        SKEW_COARSE_I,
   input  wire logic                        PLL_BYPASS_I,
   // Clock outputs
   output logic [NUM_OUTS-1:0]              CLK_OUT_O,
   output logic [NUM_OUTS-1:0]              CLK_OUT_OE_O,
   // Effective drive configuration
   output logic [NUM_BANKS*STD_W-1:0]       BANK_STD_O,
   output logic [NUM_OUTS*SLEW_W-1:0]       OUT_SLEW_O,
   output logic [NUM_OUTS*IMP_W-1:0]        OUT_IMP_O,
   output logic [NUM_OUTS-1:0]              OUT_TERM_EN_O
);
   typedef struct packed {
      logic [3:0]                   sync1;
      logic [3:0]                   sync2;
      logic [NUM_BANKS*STD_W-1:0]   std;
      logic [NUM_OUTS*SLEW_W-1:0]   slew;
      logic [NUM_OUTS*IMP_W-1:0]    imp;
      logic [NUM_OUTS-1:0]          term;
   } bcoc_top_st_t;

   bcoc_top_st_t st;
   bcoc_top_st_t next_st;

   logic                  goe_n;
   logic                  oex_n;
   logic                  oey_n;
   logic                  gate;
   logic [NUM_OUTS-1:0]   drive;
   logic [NUM_OUTS-1:0]   run;
   logic [NUM_OUTS-1:0]   inv;
   logic [NUM_OUTS-1:0]   off_vec;
   logic [NUM_OUTS-1:0]   x_vec;
   logic [NUM_BANKS-1:0]  diff;
   logic [NUM_BANKS-1:0]  low_swing;
   logic [NUM_OUTS*SKEW_W-1:0] skew;

   // Synchronised pins, second stage only
   assign goe_n = st.sync2[0];
   assign oex_n = st.sync2[1];
   assign oey_n = st.sync2[2];
   assign gate  = st.sync2[3];

   // Per-output enable, gate, polarity and skew selection
   always_comb begin
      for (int b = 0; b < NUM_BANKS; b++) begin
         diff[b]      = BANK_STD_I[b*STD_W +: STD_W] >= STD_DIFF_FIRST;
         low_swing[b] = (BANK_STD_I[b*STD_W +: STD_W] == STD_LVDS) ||
                        (BANK_STD_I[b*STD_W +: STD_W] == STD_LVPECL);
      end
      for (int o = 0; o < NUM_OUTS; o++) begin
         off_vec[o] = OUT_MODE_I[o*MODE_W +: MODE_W] == MODE_ALWAYS_OFF;
         x_vec[o]   = OUT_MODE_I[o*MODE_W +: MODE_W] == MODE_ON_X;
         case (OUT_MODE_I[o*MODE_W +: MODE_W])
            MODE_ALWAYS_ON: drive[o] = 1'b1;
            MODE_ON_X:      drive[o] = !oex_n;
            MODE_ON_Y:      drive[o] = !oey_n;
            default:        drive[o] = 1'b0;
         endcase
         drive[o] = drive[o] & !goe_n;
         run[o] = gate | !BANK_GATED_I[o/2];
         if (diff[o/2] && o[0]) begin
            // pair polarity from output A, minus line complemented
            inv[o] = !OUT_INVERT_I[o-1];
            skew[o*SKEW_W +: SKEW_W] = OUT_SKEW_I[(o-1)*SKEW_W +: SKEW_W];
         end else begin
            inv[o] = OUT_INVERT_I[o];
            skew[o*SKEW_W +: SKEW_W] = OUT_SKEW_I[o*SKEW_W +: SKEW_W];
         end
      end
   end

   // Next state: synchronisers and effective drive configuration
   always_comb begin
      next_st = st;
      if (CE_I) begin
         next_st.sync1 = {SYNC_OUTPUT_GATE_I, SECONDARY_ENABLE_Y_N_I,
                          SECONDARY_ENABLE_X_N_I, ALL_OUTPUTS_ENABLE_N_I};
         next_st.sync2 = st.sync1;
         next_st.std   = BANK_STD_I;
         for (int o = 0; o < NUM_OUTS; o++) begin
            if (low_swing[o/2]) begin
               next_st.slew[o*SLEW_W +: SLEW_W] = SLEW_FIXED;
               next_st.imp[o*IMP_W +: IMP_W] = IMP_40_OHM;
               next_st.term[o] = 1'b0;
            end else begin
               next_st.slew[o*SLEW_W +: SLEW_W] =
                  OUT_SLEW_I[o*SLEW_W +: SLEW_W];
               next_st.imp[o*IMP_W +: IMP_W] = OUT_IMP_I[o*IMP_W +: IMP_W];
               next_st.term[o] = 1'b1;
            end
         end
      end
   end

   // State register; pins reset to their inactive levels
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         st <= '{sync1: 4'hf, sync2: 4'hf, std: '0, slew: '0,
                 imp: '0, term: '0};
      end else begin
         st <= next_st;
      end
   end

   // static selections feed each output channel
   for (genvar g = 0; g < NUM_OUTS; g++) begin : g_out
      bcoc_chan u_chan (
         .clk_i    (REF_CLK_I),
         .rst_i    (SYS_RST_I),
         .ce_i     (CE_I),
         .src_i    (SRC_CLK_I),
         .skew_i   (skew[g*SKEW_W +: SKEW_W]),
         .coarse_i (SKEW_COARSE_I),
         .bypass_i (PLL_BYPASS_I),
         .inv_i    (inv[g]),
         .run_i    (run[g]),
         .drive_i  (drive[g]),
         .q_o      (CLK_OUT_O[g]),
         .oe_o     (CLK_OUT_OE_O[g])
      );
   end

   assign BANK_STD_O    = st.std;
   assign OUT_SLEW_O    = st.slew;
   assign OUT_IMP_O     = st.imp;
   assign OUT_TERM_EN_O = st.term;

   // Checks
   property p_goe;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (CE_I && goe_n) |=> (CLK_OUT_OE_O == '0);
   endproperty
   a_goe: assert property (p_goe)
      else $error("driver enabled while global enable high");

   property p_off;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      CE_I |=> ((CLK_OUT_OE_O & $past(off_vec)) == '0);
   endproperty
   a_off: assert property (p_off)
      else $error("always-off output enabled");

   property p_oex;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (CE_I && !goe_n && !oex_n) |=>
         ((CLK_OUT_OE_O & $past(x_vec)) == $past(x_vec));
   endproperty
   a_oex: assert property (p_oex)
      else $error("X-following output not driven");

   property p_slew;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (CE_I && low_swing[0]) |=> (OUT_SLEW_O[2*SLEW_W-1:0] ==
                                   {SLEW_FIXED, SLEW_FIXED});
   endproperty
   a_slew: assert property (p_slew)
      else $error("slew not fixed in low-swing mode");

   property p_term;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (CE_I && low_swing[0]) |=> (OUT_TERM_EN_O[1:0] == 2'h0);
   endproperty
   a_term: assert property (p_term)
      else $error("termination engaged in low-swing mode");
endmodule : bcoc_top

/* test/bcoc_bench.sv */
// Self-checking testbench for the clock output bank control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module bcoc_bench
   import bcoc_pkg::*;
;
   logic                       clk = 1'b0;
   logic                       rst = 1'b1;
   logic                       src = 1'b0;
   logic                       all_n, x_n, y_n, gate, coarse, bypass;
   logic                       ce = 1'b1;
   logic [6:0]                 cnt = 7'h00;
   logic [2*NUM_OUTS-1:0]      snap;
   logic [NUM_OUTS*MODE_W-1:0] mode;
   logic [NUM_OUTS-1:0]        inv, q, oe, seen, term;
   logic [NUM_BANKS-1:0]       gated;
   logic [NUM_BANKS*STD_W-1:0] std, std_q;
   logic [NUM_OUTS*SLEW_W-1:0] slew, slew_q;
   logic [NUM_OUTS*IMP_W-1:0]  imp, imp_q;
   logic [NUM_OUTS*SKEW_W-1:0] skew;
   int                         n_fail = 0;
   int                         checks_done = 0;
   int                         da, db, hi, e;

   // Reference clock and a slow source clock of 128 cycles
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cnt <= cnt + 7'h01;
      src <= cnt[6];
   end

   bcoc_top DUT (
      .REF_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .SRC_CLK_I(src),
      .ALL_OUTPUTS_ENABLE_N_I(all_n), .SECONDARY_ENABLE_X_N_I(x_n),
      .SECONDARY_ENABLE_Y_N_I(y_n), .SYNC_OUTPUT_GATE_I(gate),
      .OUT_MODE_I(mode), .OUT_INVERT_I(inv), .BANK_GATED_I(gated),
      .BANK_STD_I(std), .OUT_SLEW_I(slew), .OUT_IMP_I(imp),
      .OUT_SKEW_I(skew), .SKEW_COARSE_I(coarse), .PLL_BYPASS_I(bypass),
      .CLK_OUT_O(q), .CLK_OUT_OE_O(oe), .BANK_STD_O(std_q),
      .OUT_SLEW_O(slew_q), .OUT_IMP_O(imp_q), .OUT_TERM_EN_O(term));

   bcoc_load LOAD (.clk_i(clk), .q_i(q), .oe_i(oe), .wire_o(seen));

   // Wait edges, then sample settled outputs
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Counts and verdict
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   // Edges from a source rise to the first high on outputs 2 and 3
   task automatic measure(output int a, output int b);
      int k;
      int w;
      a = -1;
      b = -1;
      for (w = 0; w < 200 && !(src === 1'b1 && cnt == 7'h41); w++) tick(1);
      // A missed source edge skips the scan and counts as a timeout
      for (k = 1; k <= 60 && w < 200; k++) begin
         tick(1);
         if (a < 0 && seen[2] === 1'b1) a = k;
         if (b < 0 && seen[3] === 1'b1) b = k;
      end
      if (a < 0 || b < 0) begin
         $display("[ERR] edge wait exp found got timeout");
         n_fail++;
         give_verdict();
      end
   endtask : measure

   // Main sequence
   initial begin
      {all_n, x_n, y_n, gate} = 4'hf;
      {coarse, bypass} = 2'h0;
      {inv, gated, skew} = '0;
      std = {{4{STD_LVTTL}}, STD_LVDS};
      for (int o = 0; o < NUM_OUTS; o++) begin
         mode[o*MODE_W+:MODE_W] = o[1:0];
         slew[o*SLEW_W+:SLEW_W] = o[1:0];
         imp[o*IMP_W+:IMP_W] = o[2:0];
      end
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      tick(4);
      // Drive configuration per bank standard
      for (int o = 0; o < NUM_OUTS; o++) begin
         e = o < 2 ? 0 : o;
         `CHK("slew", e[1:0], slew_q[o*SLEW_W+:SLEW_W])
         `CHK("imp", e[2:0], imp_q[o*IMP_W+:IMP_W])
         `CHK("term", o >= 2, term[o])
      end
      `CHK("std", std, std_q)
      $display("test config done");
      // Enable decode over every pin combination and mode
      for (int p = 7; p >= 0; p--) begin
         @(posedge clk);
         {all_n, x_n, y_n} <= p[2:0];
         tick(5);
         for (int o = 0; o < NUM_OUTS; o++) begin
            e = !p[2] && (o % 4 == 1 || (o % 4 == 2 && !p[1])
                || (o % 4 == 3 && !p[0]));
            `CHK("oe", e[0], oe[o])
         end
      end
      $display("test enables done");
      // Differential pair: one skew, B inverse of A
      @(posedge clk);
      mode <= {NUM_OUTS{MODE_ALWAYS_ON}};
      skew <= 40'h93;
      tick(140);
      for (int i = 0; i < 128; i++) begin
         tick(1);
         `CHK("pair", ~seen[0], seen[1])
      end
      $display("test pair done");
      // Delay difference per skew setting, unit size and path
      for (int c = 0; c < 4; c++) begin
         for (int s = 1; s < 16; s += 14) begin
            @(posedge clk);
            {bypass, coarse} <= c[1:0];
            skew[2*SKEW_W+:SKEW_W] <= s[3:0];
            tick(130);
            measure(da, db);
            e = c[1] ? 0 : s * (c[0] ? 2 : 1);
            `CHK("skew", e, da - db)
         end
      end
      $display("test skew done");
      // Gated bank parks at polarity level, bank 2 output 4 runs on
      @(posedge clk);
      gated <= 5'h02;
      inv <= 10'h008;
      gate <= 1'b0;
      tick(140);
      hi = 0;
      for (int i = 0; i < 128; i++) begin
         tick(1);
         `CHK("parked", 2'h2, seen[3:2])
         `CHK("driven", 2'h3, oe[3:2])
         hi += seen[4];
      end
      `CHK("ungated", 64, hi)
      // Gate opened and closed at odd moments gives whole pulses
      hi = 0;
      for (int i = 0; i < 400; i++) begin
         @(posedge clk);
         if (i == 30) gate <= 1'b1;
         if (i == 250) gate <= 1'b0;
         #1;
         if (seen[2] === 1'b1) hi++;
         else if (hi > 0) begin
            `CHK("pulse", 64, hi)
            hi = 0;
         end
      end
      $display("test gate done");
      // Clock enable low freezes every output, pin changes included
      @(posedge clk);
      ce <= 1'b0;
      all_n <= 1'b1;
      tick(1);
      snap = {q, oe};
      for (int i = 0; i < 20; i++) begin
         tick(1);
         `CHK("frozen", snap, {q, oe})
      end
      @(posedge clk);
      ce <= 1'b1;
      tick(5);
      `CHK("oe off", 10'h000, oe)
      $display("test freeze done");
      give_verdict();
   end
endmodule : bcoc_bench

/* test/bcoc_load.sv */
// Board load model: level seen on each clock output line
`timescale 1ns/1ps
module bcoc_load
   import bcoc_pkg::*;
(
   // Clock
   input  wire logic                clk_i,
   // Pin drive from the device
   input  wire logic [NUM_OUTS-1:0] q_i,
   input  wire logic [NUM_OUTS-1:0] oe_i,
   // Level on the board
   output logic      [NUM_OUTS-1:0] wire_o
);
   logic [NUM_OUTS-1:0] held = '0;

   // Floating lines flip every cycle, so they never pass for a level
   always @(posedge clk_i) begin
      held <= wire_o;
   end
   assign wire_o = (q_i & oe_i) | (~held & ~oe_i);
endmodule : bcoc_load
